// [rtl/afc_pkg.sv]
// Package of constants and types for the auxiliary function code output bank.
package afc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices; the byte address is four times the index.
  localparam int ADDR_W = 12;
  localparam logic [7:0] IDX_SPD_CMD1 = 8'h08;
  localparam logic [7:0] IDX_SPD_FINAL1 = 8'h0A;
  localparam logic [7:0] IDX_KEY_IN = 8'h10;
  localparam logic [7:0] IDX_SPD_MEAS1 = 8'h12;
  localparam logic [7:0] IDX_MCODE1 = 8'h14;
  localparam logic [7:0] IDX_MCODE2 = 8'h16;
  localparam logic [7:0] IDX_MCODE3 = 8'h18;
  localparam logic [7:0] IDX_MCODE4 = 8'h1A;
  localparam logic [7:0] IDX_SCODE1 = 8'h1C;
  localparam logic [7:0] IDX_SCODE2 = 8'h1E;
  localparam logic [7:0] IDX_TCODE1 = 8'h24;
  localparam logic [7:0] IDX_SPD_CMD2 = 8'hD0;
  localparam logic [7:0] IDX_SPD_FINAL2 = 8'hD2;
  localparam logic [7:0] IDX_SPD_MEAS2 = 8'hDA;
  localparam logic [7:0] IDX_CTRL = 8'hE0;
  localparam logic [7:0] IDX_STATUS = 8'hE1;

  ////////////////////////////////////////////////////////////////////////////
  // Control register layout and reset value.
  localparam int CTRL_MLIM_LSB = 0;
  localparam int CTRL_STDSEQ_BIT = 4;
  localparam logic [2:0] CTRL_MLIM_RESET = 3'h4;
  localparam logic CTRL_STDSEQ_RESET = 1'h0;
  localparam logic [2:0] M_PER_BLOCK_MAX = 3'h4;

  // Status register layout.
  localparam int STAT_PEND_LSB = 0;
  localparam int STAT_MCOUNT_LSB = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Data constants.
  localparam logic [31:0] M_SUBCALL = 32'h00000098;
  localparam logic [31:0] M_SUBRET = 32'h00000099;
  localparam logic [31:0] MEAS_SCALE = 32'h000003E8;
  localparam logic [39:0] OVR_UNIT = 40'h0000000064;
  localparam logic [31:0] WORD_RESET = 32'h00000000;
  localparam logic [31:0] ORIENT_SPEED = 32'h00000064;
  localparam logic [31:0] GEAR_SHIFT_SPEED = 32'h00000032;
  localparam logic [31:0] GEAR_MAX_0 = 32'h000003E8;
  localparam logic [31:0] GEAR_MAX_1 = 32'h000007D0;
  localparam logic [31:0] GEAR_MAX_2 = 32'h00000FA0;
  localparam logic [31:0] GEAR_MAX_3 = 32'h00001F40;

  // Bus answers.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Pin synchroniser width.
  localparam int SYNC_W = 15;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {AFC_SRC_AUTO, AFC_SRC_MANUAL, AFC_SRC_CYCLE} afc_src_t;

  typedef enum logic [0:0] {AFC_WR_COLLECT, AFC_WR_RESP} afc_wr_state_t;

  // One block of M commands, in program order.
  typedef struct packed {
    logic valid;
    afc_src_t src;
    logic indep;
    logic [2:0] count;
    logic [3:0][31:0] code;
  } afc_mblock_t;

  // One S or T command.
  typedef struct packed {
    logic valid;
    afc_src_t src;
    logic spindle;
    logic [31:0] value;
  } afc_cmd_t;

  // Machine-side conditions for one spindle.
  typedef struct packed {
    logic gear_select_in_1;
    logic gear_select_in_2;
    logic spindle_halt;
    logic spindle_gear_change;
    logic orientation_speed_cmd;
  } afc_spcond_t;

endpackage

// [rtl/afc_spindle_final.sv]
// Final spindle command computation for one spindle.
module afc_spindle_final
  import afc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [31:0] i_cmd_speed,
  input wire logic [7:0] i_override,
  input wire afc_spcond_t i_cond,
  output logic [31:0] o_final
);

  logic [39:0] scaled;
  logic [31:0] ovr_speed;
  logic [31:0] gear_max;
  logic [31:0] final_d;
  logic [31:0] final_q;

  // Gear limit picked by the two gear select inputs.
  always_comb begin
    case ({i_cond.gear_select_in_2, i_cond.gear_select_in_1})
      2'h0: gear_max = GEAR_MAX_0;
      2'h1: gear_max = GEAR_MAX_1;
      2'h2: gear_max = GEAR_MAX_2;
      default: gear_max = GEAR_MAX_3;
    endcase
  end

  always_comb begin
    scaled = (40'(i_cmd_speed) * 40'(i_override)) / OVR_UNIT;
    ovr_speed = (scaled > 40'(gear_max)) ? gear_max : scaled[31:0];
  end

  // Halt wins over orientation, orientation over gear change.
  always_comb begin
    if (i_cond.spindle_halt) begin
      final_d = WORD_RESET;
    end else if (i_cond.orientation_speed_cmd) begin
      final_d = ORIENT_SPEED;
    end else if (i_cond.spindle_gear_change) begin
      final_d = GEAR_SHIFT_SPEED;
    end else begin
      final_d = ovr_speed;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      final_q <= WORD_RESET;
    end else begin
      final_q <= final_d;
    end
  end

  assign o_final = final_q;

endmodule

// [rtl/afc_code_bank.sv]
// Auxiliary function code output bank with an AXI4-Lite register port.
//
// Function
// - Commit S speed only on finish or gear-done
// - Reset and emergency stop keep S speed
// - Surface speed mode loads the surface speed value
// - S speed word holds plain revolutions per minute
// - Final command applies override, gears, halt, orientation
// - Key word follows operator keys while typing
// - Measured speed always loaded, times one thousand
// - M words are up to eight BCD digits
// - M word one updates on auto, cycle, manual
// - Independent M output updates despite function lock
// - M words held through finish, reset, stop
// - Up to four M per block; standard one
// - Several M words keep program order
// - Subprogram call and return never presented
// - M words two to four need auto source and enough M
// - S code words binary, held through reset
// - S word one and two at fixed pair
// - Last S per spindle in block wins
// - T word BCD, updated on T, held
module afc_code_bank
  import afc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire afc_cmd_t i_s_cmd,
  input wire logic [1:0] i_css_active,
  input wire logic [1:0][31:0] i_css_value,
  input wire afc_mblock_t i_m_block,
  input wire logic i_aux_lock,
  input wire afc_cmd_t i_t_cmd,
  input wire logic i_key_active,
  input wire logic [15:0] i_key_code,
  input wire logic [1:0][31:0] i_enc_rpm,
  input wire logic [1:0][7:0] i_override,
  input wire logic i_aux_finish_ack_1,
  input wire logic i_aux_finish_ack_2,
  input wire logic i_gear_shift_done_ack,
  input wire afc_spcond_t [1:0] i_sp_cond,
  input wire logic i_nc_reset,
  input wire logic i_estop,
  output logic [1:0] o_s_pending
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  logic [SYNC_W-1:0] pins;
  logic [SYNC_W-1:0] sync_a_q;
  logic [SYNC_W-1:0] sync_b_q;
  logic fin_prev_q;
  logic fin_any;
  logic fin_event;
  logic abort;
  afc_spcond_t [1:0] cond_s;

  assign pins = {i_aux_finish_ack_1, i_aux_finish_ack_2, i_gear_shift_done_ack,
                 i_sp_cond[1], i_sp_cond[0], i_nc_reset, i_estop};

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sync_a_q <= '0;
      sync_b_q <= '0;
    end else begin
      sync_a_q <= pins;
      sync_b_q <= sync_a_q;
    end
  end

  assign fin_any = sync_b_q[14] | sync_b_q[13] | sync_b_q[12];
  assign cond_s[1] = sync_b_q[11:7];
  assign cond_s[0] = sync_b_q[6:2];
  assign abort = sync_b_q[1] | sync_b_q[0];

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      fin_prev_q <= 1'b0;
    end else begin
      fin_prev_q <= fin_any;
    end
  end

  assign fin_event = fin_any & ~fin_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Control register.
  logic [2:0] mlim_q;
  logic stdseq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Spindle command speed: staged at the S command, committed on finish.
  logic [1:0] pend_q;
  logic [1:0][31:0] pend_val_q;
  logic [1:0][31:0] spd_cmd_q;
  logic [1:0][31:0] scode_q;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pend_q <= '0;
      pend_val_q <= '0;
    end else begin
      for (int sp = 0; sp < 2; sp++) begin
        if (i_s_cmd.valid && i_s_cmd.spindle == sp[0]) begin
          pend_q[sp] <= 1'b1;
          pend_val_q[sp] <= i_s_cmd.value;
        end else if (fin_event || abort) begin
          pend_q[sp] <= 1'b0;
        end
      end
    end
  end

  // Only the hardware reset clears the speed word; the machine reset and the
  // emergency stop drop a staged command but leave the word untouched.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      spd_cmd_q <= '0;
    end else begin
      for (int sp = 0; sp < 2; sp++) begin
        if (fin_event && pend_q[sp] && !abort) begin
          if (i_css_active[sp]) begin
            spd_cmd_q[sp] <= i_css_value[sp];
          end else begin
            spd_cmd_q[sp] <= pend_val_q[sp];
          end
        end
      end
    end
  end

  // S code words are binary and take the latest S of each spindle at once.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      scode_q <= '0;
    end else if (i_s_cmd.valid) begin
      scode_q[i_s_cmd.spindle] <= i_s_cmd.value;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Final spindle commands.
  logic [1:0][31:0] spd_final;

  for (genvar g = 0; g < 2; g++) begin : g_final
    afc_spindle_final u_final (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_cmd_speed(spd_cmd_q[g]),
      .i_override(i_override[g]),
      .i_cond(cond_s[g]),
      .o_final(spd_final[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Key-in word and measured speed.
  logic [15:0] key_q;
  logic [1:0][31:0] meas_q;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      key_q <= '0;
    end else if (i_key_active) begin
      key_q <= i_key_code;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      meas_q <= '0;
    end else begin
      for (int sp = 0; sp < 2; sp++) begin
        meas_q[sp] <= 32'(i_enc_rpm[sp] * MEAS_SCALE);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // M code words.
  logic [2:0] m_limit;
  logic [3:0][31:0] m_pack;
  logic [2:0] m_n;
  logic m_allowed;
  logic [3:0][31:0] mcode_q;
  logic [2:0] m_last_q;

  always_comb begin
    if (stdseq_q || mlim_q == 3'h0) begin
      m_limit = 3'h1;
    end else if (mlim_q > M_PER_BLOCK_MAX) begin
      m_limit = M_PER_BLOCK_MAX;
    end else begin
      m_limit = mlim_q;
    end
  end

  // Packs the block's codes in program order, dropping subprogram codes.
  always_comb begin
    m_pack = '0;
    m_n = 3'h0;
    for (int i = 0; i < 4; i++) begin
      if (3'(i) < i_m_block.count && i_m_block.code[i] != M_SUBCALL &&
          i_m_block.code[i] != M_SUBRET && m_n < m_limit) begin
        m_pack[m_n[1:0]] = i_m_block.code[i];
        m_n = m_n + 3'h1;
      end
    end
  end

  assign m_allowed = i_m_block.valid && (!i_aux_lock || i_m_block.indep);

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      mcode_q <= '0;
      m_last_q <= '0;
    end else if (m_allowed && m_n != 3'h0) begin
      m_last_q <= m_n;
      mcode_q[0] <= m_pack[0];
      for (int j = 1; j < 4; j++) begin
        if (i_m_block.src == AFC_SRC_AUTO && m_n > 3'(j)) begin
          mcode_q[j] <= m_pack[j];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // T code word.
  logic [31:0] tcode_q;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      tcode_q <= '0;
    end else if (i_t_cmd.valid) begin
      tcode_q <= i_t_cmd.value;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write side.
  afc_wr_state_t wr_state_q;
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] aw_idx_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q;
  logic aw_take;
  logic w_take;

  assign aw_take = i_awvalid && o_awready;
  assign w_take = i_wvalid && o_wready;
  assign o_awready = (wr_state_q == AFC_WR_COLLECT) && !aw_held_q;
  assign o_wready = (wr_state_q == AFC_WR_COLLECT) && !w_held_q;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      aw_idx_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      if (aw_take) begin
        aw_idx_q <= i_awaddr[9:2];
      end
      if (w_take) begin
        wdata_q <= i_wdata;
        wstrb_q <= i_wstrb;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wr_state_q <= AFC_WR_COLLECT;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      case (wr_state_q)
        AFC_WR_COLLECT: begin
          if ((aw_held_q || aw_take) && (w_held_q || w_take)) begin
            wr_state_q <= AFC_WR_RESP;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            bresp_q <= ((aw_take ? i_awaddr[9:2] : aw_idx_q) == IDX_CTRL) ? RESP_OKAY : RESP_SLVERR;
          end else begin
            aw_held_q <= aw_held_q | aw_take;
            w_held_q <= w_held_q | w_take;
          end
        end
        AFC_WR_RESP: begin
          if (i_bready) begin
            wr_state_q <= AFC_WR_COLLECT;
          end
        end
        default: begin
          wr_state_q <= AFC_WR_COLLECT;
        end
      endcase
    end
  end

  // The control register commits in the cycle the response is raised.
  logic wr_commit;
  logic [31:0] wr_data_eff;
  logic [3:0] wr_strb_eff;
  logic [7:0] wr_idx_eff;

  assign wr_commit = (wr_state_q == AFC_WR_COLLECT) && (aw_held_q || aw_take) && (w_held_q || w_take);
  assign wr_data_eff = w_take ? i_wdata : wdata_q;
  assign wr_strb_eff = w_take ? i_wstrb : wstrb_q;
  assign wr_idx_eff = aw_take ? i_awaddr[9:2] : aw_idx_q;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      mlim_q <= CTRL_MLIM_RESET;
      stdseq_q <= CTRL_STDSEQ_RESET;
    end else if (wr_commit && wr_idx_eff == IDX_CTRL && wr_strb_eff[0]) begin
      mlim_q <= wr_data_eff[CTRL_MLIM_LSB +: 3];
      stdseq_q <= wr_data_eff[CTRL_STDSEQ_BIT];
    end
  end

  assign o_bvalid = (wr_state_q == AFC_WR_RESP);
  assign o_bresp = bresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read side.
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [31:0] rd_word;
  logic rd_hit;

  always_comb begin
    rd_hit = 1'b1;
    case (i_araddr[9:2])
      IDX_SPD_CMD1: rd_word = spd_cmd_q[0];
      IDX_SPD_FINAL1: rd_word = spd_final[0];
      IDX_KEY_IN: rd_word = {16'h0000, key_q};
      IDX_SPD_MEAS1: rd_word = meas_q[0];
      IDX_MCODE1: rd_word = mcode_q[0];
      IDX_MCODE2: rd_word = mcode_q[1];
      IDX_MCODE3: rd_word = mcode_q[2];
      IDX_MCODE4: rd_word = mcode_q[3];
      IDX_SCODE1: rd_word = scode_q[0];
      IDX_SCODE2: rd_word = scode_q[1];
      IDX_TCODE1: rd_word = tcode_q;
      IDX_SPD_CMD2: rd_word = spd_cmd_q[1];
      IDX_SPD_FINAL2: rd_word = spd_final[1];
      IDX_SPD_MEAS2: rd_word = meas_q[1];
      IDX_CTRL: rd_word = 32'({stdseq_q, 1'b0, mlim_q});
      IDX_STATUS: rd_word = 32'({m_last_q, 2'b00, pend_q});
      default: begin
        rd_word = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
    if (i_araddr[ADDR_W-1:10] != '0) begin
      rd_word = 32'h00000000;
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (i_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && i_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign o_arready = !rvalid_q;
  assign o_rvalid = rvalid_q;
  assign o_rdata = rdata_q;
  assign o_rresp = rresp_q;
  assign o_s_pending = pend_q;

endmodule

// [tb/afc_bank_checker.sv]
// Bus and staging assertions for the code bank.
module afc_bank_checker
  import afc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic [1:0] o_bresp,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_aux_finish_ack_1,
  input wire logic [1:0] o_s_pending
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence wr_taken;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  sequence rd_taken;
    i_arvalid && o_arready;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  wr_refuse_a: assert property (wr_taken ##0 (i_awaddr != 12'h380) |=> o_bvalid && o_bresp == RESP_SLVERR)
    else $error("write to read-only word not refused");
  wr_accept_a: assert property (wr_taken ##0 (i_awaddr == 12'h380 && i_wstrb[0]) |=> o_bvalid && o_bresp == RESP_OKAY)
    else $error("control write not accepted");
  bus_busy_a: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write channels open while response pending");
  bresp_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped early");
  rd_answer_a: assert property (rd_taken |=> o_rvalid)
    else $error("read not answered next cycle");
  rd_refuse_a: assert property (rd_taken ##0 (i_araddr[11:10] != 2'h0) |=> o_rresp == RESP_SLVERR && o_rdata == 32'h0)
    else $error("out of range read not refused");
  rdata_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data changed while waiting");
  rd_release_a: assert property (o_rvalid && i_rready |=> !o_rvalid)
    else $error("read response not released");
  fin_commit_a: assert property (i_aux_finish_ack_1 [*4] |-> o_s_pending == 2'h0)
    else $error("staged speed not committed on finish");
endmodule

// [tb/afc_fin_model.sv]
// Sequence controller model that answers staged speeds with a finish.
module afc_fin_model (
  input wire logic i_clk,
  input wire logic i_slow,
  input wire logic [1:0] i_pend,
  output logic o_fin
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned wait_q = 0;
  initial o_fin = 1'h0;
  // The finish is held until the staged speed is gone, as a real controller would.
  always @(posedge i_clk) begin
    if (i_pend == 2'h0) begin
      o_fin <= 1'h0;
      wait_q <= 0;
    end else if (wait_q >= (i_slow ? 20 : 2)) begin
      o_fin <= 1'h1;
    end else begin
      wait_q <= wait_q + 1;
    end
  end
endmodule

// [tb/tb.sv]
// Self-checking bench for the code bank.
module tb
  import afc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'h0, i_reset = 1'h1, slow = 1'h1;
  logic [ADDR_W-1:0] i_awaddr = 12'h0, i_araddr = 12'h0;
  logic [31:0] i_wdata = 32'h0, o_rdata;
  logic [3:0] i_wstrb = 4'hF;
  logic i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0, i_arvalid = 1'h0, i_rready = 1'h0;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, i_aux_finish_ack_1;
  logic [1:0] o_bresp, o_rresp, o_s_pending, i_css_active = 2'h0;
  afc_cmd_t i_s_cmd = '0, i_t_cmd = '0;
  afc_mblock_t i_m_block = '0;
  logic [1:0][31:0] i_css_value = 64'h0, i_enc_rpm = 64'h0;
  logic [1:0][7:0] i_override = 16'h6464;
  afc_spcond_t [1:0] i_sp_cond = '0;
  logic i_aux_lock = 1'h0, i_key_active = 1'h0, i_aux_finish_ack_2 = 1'h0;
  logic i_gear_shift_done_ack = 1'h0, i_nc_reset = 1'h0, i_estop = 1'h0;
  logic [15:0] i_key_code = 16'h0;
  int bad_count = 0, comparisons = 0;

  always #2 i_clk = ~i_clk;

  afc_code_bank uut (.*);
  afc_fin_model seq (.i_clk(i_clk), .i_slow(slow), .i_pend(o_s_pending), .o_fin(i_aux_finish_ack_1));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [11:0] ba(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction
  function automatic logic [31:0] bcd();
    logic [31:0] v;
    for (int k = 0; k < 8; k++) v[4*k+:4] = 4'($urandom % 10);
    return v;
  endfunction
  function automatic logic [31:0] efin(input logic [31:0] v);
    return (v > GEAR_MAX_0) ? GEAR_MAX_0 : v;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge i_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'h1;
    i_wvalid <= 1'h1;
    do begin
      @(posedge i_clk);
      if (o_awready) i_awvalid <= 1'h0;
      if (o_wready) i_wvalid <= 1'h0;
      if (o_bvalid && !i_bready) i_bready <= 1'h1;
    end while (!(o_bvalid && i_bready));
    i_bready <= 1'h0;
    chk({30'h0, o_bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
    @(posedge i_clk);
    i_araddr <= a;
    i_arvalid <= 1'h1;
    do begin
      @(posedge i_clk);
      if (o_arready && i_arvalid) i_arvalid <= 1'h0;
      if (o_rvalid && !i_rready) i_rready <= 1'h1;
    end while (!(o_rvalid && i_rready));
    i_rready <= 1'h0;
    chk(o_rdata, e);
    chk({30'h0, o_rresp}, {30'h0, er});
  endtask
  task automatic idle();
    @(posedge i_clk);
    i_s_cmd.valid <= 1'h0;
    i_m_block.valid <= 1'h0;
    i_t_cmd.valid <= 1'h0;
  endtask
  task automatic scmd(input logic sp, input logic [31:0] v);
    @(posedge i_clk);
    i_s_cmd <= {1'h1, afc_src_t'($urandom % 2), sp, v};
  endtask
  task automatic mcmd(input afc_src_t s, input logic ind, input logic [2:0] n, input logic [127:0] c);
    @(posedge i_clk);
    i_m_block <= {1'h1, s, ind, n, c};
    idle();
  endtask
  task automatic settle();
    do @(posedge i_clk); while (o_s_pending != 2'h0);
    repeat (3) @(posedge i_clk);
  endtask
  task automatic test_done();
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge i_clk);
    bad_count++;
    test_done();
  end

  initial begin
    logic [31:0] v, v2, prev, cv, e0, e1, m;
    logic [127:0] c, c2;
    logic [15:0] k;
    void'($urandom(32'h5C450277));
    repeat (10) @(posedge i_clk);
    i_reset <= 1'h0;
    rd(ba(IDX_CTRL), 32'h4);
    e0 = 32'($urandom % 4000);
    e1 = 32'($urandom % 4000);
    k = 16'($urandom);
    i_enc_rpm <= {e1, e0};
    i_key_active <= 1'h1;
    i_key_code <= k;
    rd(ba(IDX_SPD_MEAS1), e0 * MEAS_SCALE);
    rd(ba(IDX_SPD_MEAS2), e1 * MEAS_SCALE);
    rd(ba(IDX_KEY_IN), {16'h0, k});
    i_key_active <= 1'h0;
    c = {bcd(), bcd(), M_SUBCALL, bcd()};
    mcmd(AFC_SRC_AUTO, 1'h0, 3'h4, c);
    rd(ba(IDX_MCODE1), c[31:0]);
    rd(ba(IDX_MCODE2), c[95:64]);
    rd(ba(IDX_MCODE3), c[127:96]);
    rd(ba(IDX_MCODE4), 32'h0);
    c2 = {64'h0, bcd(), bcd()};
    mcmd(AFC_SRC_MANUAL, 1'h0, 3'h2, c2);
    rd(ba(IDX_MCODE1), c2[31:0]);
    rd(ba(IDX_MCODE2), c[95:64]);
    m = bcd();
    mcmd(AFC_SRC_CYCLE, 1'h0, 3'h1, {96'h0, m});
    rd(ba(IDX_MCODE1), m);
    i_aux_lock <= 1'h1;
    mcmd(AFC_SRC_AUTO, 1'h0, 3'h1, {96'h0, c[31:0]});
    rd(ba(IDX_MCODE1), m);
    m = bcd();
    mcmd(AFC_SRC_AUTO, 1'h1, 3'h1, {96'h0, m});
    rd(ba(IDX_MCODE1), m);
    i_aux_lock <= 1'h0;
    wr(ba(IDX_CTRL), 32'h14, RESP_OKAY);
    c2 = {64'h0, bcd(), bcd()};
    mcmd(AFC_SRC_AUTO, 1'h0, 3'h2, c2);
    rd(ba(IDX_MCODE1), c2[31:0]);
    rd(ba(IDX_MCODE2), c[95:64]);
    wr(ba(IDX_MCODE1), 32'h0, RESP_SLVERR);
    rd(12'hC00, 32'h0, RESP_SLVERR);
    rd(ba(8'h01), 32'h0, RESP_SLVERR);
    v = bcd();
    @(posedge i_clk);
    i_t_cmd <= {1'h1, afc_src_t'($urandom % 2), 1'h0, v};
    idle();
    rd(ba(IDX_TCODE1), v);
    prev = 32'h0;
    for (int r = 0; r < 3; r++) begin
      v = 32'($urandom % 2000);
      v2 = 32'($urandom % 2000);
      scmd(1'h0, v);
      scmd(1'h0, v2);
      idle();
      rd(ba(IDX_SCODE1), v2);
      rd(ba(IDX_SPD_CMD1), prev);
      settle();
      rd(ba(IDX_SPD_CMD1), v2);
      rd(ba(IDX_SPD_FINAL1), efin(v2));
      @(posedge i_clk);
      i_nc_reset <= 1'h1;
      i_estop <= 1'h1;
      repeat (6) @(posedge i_clk);
      i_nc_reset <= 1'h0;
      i_estop <= 1'h0;
      rd(ba(IDX_SPD_CMD1), v2);
      rd(ba(IDX_SCODE1), v2);
      prev = v2;
    end
    rd(ba(IDX_MCODE1), c2[31:0]);
    slow <= 1'h0;
    v = 32'($urandom % 2000);
    cv = 32'($urandom % 2000);
    i_css_active <= 2'h2;
    i_css_value[1] <= cv;
    scmd(1'h1, v);
    idle();
    settle();
    rd(ba(IDX_SCODE2), v);
    rd(ba(IDX_SPD_CMD2), cv);
    test_done();
  end
endmodule

bind afc_code_bank afc_bank_checker chk (.*);
